// >>> design/sbs_pkg.sv
// Package of constants and carrier types for the statistics report block
// ==========================================================================
// Summary of operation
// [R1] Command byte 16H decodes as the statistics report or clear request.
// [R2] Host sets the adapter identifier field to FFH for this board-control request.
// [R3] Command identifier is unique and is returned with the completion.
// [R4] Address modifier from the parameter block drives writes; unused when clearing.
// [R5] Structure is written from the supplied memory address; unused when clearing.
// [R6] Clear option zeroes all counters with no transfer; otherwise counters are reported.
// [R7] Counters clear only on reset or a clearing command; otherwise they accumulate.
// [R8] Format option 0 gives the 8-ID layout, 1 the 16-ID layout.
// [R9] Every processed command is counted and reported in word 00H.
// [R10] A non-Good status from any device bumps the bad-status counter.
// [R11] Every SCSI parity error bumps the parity counter.
// [R12] Each selection as a target is counted and reported at 0CH.
// [R13] Per-target command counts for 16 IDs; own and unused IDs read zero.
// [R14] Per-target count of Queue Full statuses.
// [R15] Per-target highest number of simultaneously queued commands.
// [R16] Header words end in reserved 1CH; per-target entries end in reserved D0H.
// [R17] Host puts address at 08H, command and options at 10H, zeroes reserved words.
// [R18] Counters are 32 bits and wrap silently on overflow.
// [R19] Clear option is options bit 0, format option bit 1; other bits ignored.
package sbs_pkg;
    // ======================================================================
    // Command decode
    localparam logic [7:0] SBS_CMD_CODE = 8'h16;
    localparam logic [7:0] SBS_ADAPTER_ID = 8'hff;
    localparam int SBS_OPT_WIPE_BIT = 0;
    localparam int SBS_OPT_SPAN_BIT = 1;
    // ======================================================================
    // Structure layout, byte offsets
    localparam logic [7:0] SBS_OFS_TOTAL = 8'h00;
    localparam logic [7:0] SBS_OFS_BAD = 8'h04;
    localparam logic [7:0] SBS_OFS_PARITY = 8'h08;
    localparam logic [7:0] SBS_OFS_TSEL = 8'h0c;
    localparam logic [7:0] SBS_OFS_HDR_RSV = 8'h1c;
    localparam logic [7:0] SBS_OFS_TGT_BASE = 8'h20;
    localparam logic [7:0] SBS_OFS_LAST_RSV = 8'hd0;
    localparam int SBS_HDR_WORDS = 8;
    localparam int SBS_TGT_WORDS = 4;
    localparam int SBS_NUM_IDS = 16;
    localparam int SBS_LEGACY_IDS = 8;
    localparam logic [31:0] SBS_CNT_RESET = 32'h0000_0000;
    localparam logic [5:0] SBS_WORDS_16 = 6'h28;
    localparam logic [5:0] SBS_WORDS_8 = 6'h18;
    localparam logic [5:0] SBS_LAST_16 = 6'h34;

    // ======================================================================
    // Carrier types
    typedef struct packed {
        logic [31:0] cmd_id;
        logic [5:0] addr_mod;
        logic [31:0] mem_addr;
        logic [7:0] cmd_code;
        logic [7:0] options;
    } sbs_req_t;

    typedef struct packed {
        logic valid;
        logic [5:0] addr_mod;
        logic [31:0] addr;
        logic [31:0] data;
    } sbs_wr_t;

    typedef struct packed {
        logic cmd_done;
        logic bad_status;
        logic parity_err;
        logic target_sel;
        logic tgt_cmd;
        logic [3:0] tgt_cmd_id;
        logic queue_full;
        logic [3:0] qf_id;
        logic depth_upd;
        logic [3:0] depth_id;
        logic [31:0] depth;
    } sbs_evt_t;

    typedef enum logic [1:0] {
        SBS_IDLE,
        SBS_WIPE,
        SBS_SEND,
        SBS_DONE
    } sbs_state_t;
endpackage : sbs_pkg

// >>> design/sbs_cnt_mem.sv
// Per-target counter memory: one word per target and field, registered read
`timescale 1ns/1ps
`default_nettype none
module sbs_cnt_mem
    import sbs_pkg::*;
#(
    parameter int DEPTH = 48,
    parameter int AW = 6
)(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic wipe_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic wr_en_in,
    input wire logic [31:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [31:0] rd_data_out
);
    logic [31:0] mem_r [DEPTH];
    logic [31:0] rd_r;

    // ======================================================================
    // Storage; a wipe zeroes every word in one edge so no clear pass is needed
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_r[i] <= SBS_CNT_RESET;
            rd_r <= SBS_CNT_RESET;
        end
        else
        begin
            if (wipe_in)
            begin
                for (int i = 0; i < DEPTH; i++)
                    mem_r[i] <= SBS_CNT_RESET; // R6
            end
            else if (wr_en_in)
                mem_r[wr_addr_in] <= wr_data_in;
            rd_r <= mem_r[rd_addr_in];
        end
    end

    assign rd_data_out = rd_r;
endmodule : sbs_cnt_mem
`default_nettype wire

// >>> design/sbs_stats_report.sv
// Statistics report and clear engine with counters and memory write port
`timescale 1ns/1ps
`default_nettype none
module sbs_stats_report
    import sbs_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [3:0] own_id_in,
    input wire logic [15:0] id_used_in,
    input wire logic req_valid_in,
    input wire sbs_req_t req_in,
    output logic req_ready_out,
    input wire sbs_evt_t evt_in,
    output sbs_wr_t wr_out,
    input wire logic wr_ready_in,
    output logic done_out,
    output logic [31:0] done_id_out,
    output logic done_wiped_out
);
    // ======================================================================
    // Whole block state in one packed struct
    typedef struct packed {
        sbs_state_t st;
        logic [31:0] total;
        logic [31:0] bad;
        logic [31:0] parity;
        logic [31:0] tsel;
        logic [31:0] cmd_id;
        logic [5:0] addr_mod;
        logic [31:0] base;
        logic span16;
        logic [5:0] word;
        logic [5:0] last;
        logic rd_pend;
        sbs_wr_t wr;
        logic done;
        logic wiped;
        logic [1:0] upd_ph;
        logic [5:0] upd_addr;
        logic [31:0] depth;
        logic [1:0] upd_kind;
    } sbs_state_all_t;

    sbs_state_all_t state_r;
    sbs_state_all_t state_nxt;

    logic mem_wipe;
    logic mem_we;
    logic [5:0] mem_waddr;
    logic [31:0] mem_wdata;
    logic [5:0] mem_raddr;
    logic [31:0] mem_rdata;

    // Map a target and field to a memory word (field 0 cmd, 1 qfull, 2 max)
    function automatic logic [5:0] sbs_slot(input logic [3:0] id, input logic [1:0] fld);
        sbs_slot = {fld, id};
    endfunction : sbs_slot

    // Decode of a header word index to a counter value
    function automatic logic [31:0] sbs_hdr_word(input sbs_state_all_t s, input logic [5:0] w);
        unique case (w[2:0])
            3'd0: sbs_hdr_word = s.total; // R9
            3'd1: sbs_hdr_word = s.bad;
            3'd2: sbs_hdr_word = s.parity;
            3'd3: sbs_hdr_word = s.tsel; // R12
            default: sbs_hdr_word = SBS_CNT_RESET; // R16
        endcase
    endfunction : sbs_hdr_word

    // ======================================================================
    // Per-target memory
    sbs_cnt_mem #(
        .DEPTH(48),
        .AW(6)
    ) u_mem (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .wipe_in(mem_wipe),
        .wr_addr_in(mem_waddr),
        .wr_en_in(mem_we),
        .wr_data_in(mem_wdata),
        .rd_addr_in(mem_raddr),
        .rd_data_out(mem_rdata)
    );

    logic is_cmd;
    logic [3:0] tid;
    logic [1:0] tfld;
    logic tgt_word;

    // ======================================================================
    // Next-state logic
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.done = 1'b0;
        mem_wipe = 1'b0;
        mem_we = 1'b0;
        mem_waddr = state_r.upd_addr;
        mem_wdata = mem_rdata + 32'h0000_0001; // R18
        mem_raddr = state_r.upd_addr;
        is_cmd = req_in.cmd_code == SBS_CMD_CODE; // R1
        // Entry k of the per-target area: word index minus header, four words each
        tid = 4'((state_r.word - 6'(SBS_HDR_WORDS)) >> 2);
        tfld = 2'(state_r.word - 6'(SBS_HDR_WORDS));
        tgt_word = state_r.word >= 6'(SBS_HDR_WORDS);

        // Scalar counters accumulate between clears
        if (evt_in.cmd_done)
            state_nxt.total = state_r.total + 32'h0000_0001; // R9 R18
        if (evt_in.bad_status)
            state_nxt.bad = state_r.bad + 32'h0000_0001; // R10
        if (evt_in.parity_err)
            state_nxt.parity = state_r.parity + 32'h0000_0001; // R11
        if (evt_in.target_sel)
            state_nxt.tsel = state_r.tsel + 32'h0000_0001; // R12

        // Per-target read-modify-write, one event at a time, two-cycle phase
        unique case (state_r.upd_ph)
            2'd0:
            begin
                if (state_r.st == SBS_IDLE || state_r.st == SBS_DONE)
                begin
                    if (evt_in.tgt_cmd && evt_in.tgt_cmd_id != own_id_in)
                    begin
                        state_nxt.upd_addr = sbs_slot(evt_in.tgt_cmd_id, 2'd0); // R13
                        state_nxt.upd_kind = 2'd0;
                        state_nxt.upd_ph = 2'd1;
                    end
                    else if (evt_in.queue_full)
                    begin
                        state_nxt.upd_addr = sbs_slot(evt_in.qf_id, 2'd1); // R14
                        state_nxt.upd_kind = 2'd1;
                        state_nxt.upd_ph = 2'd1;
                    end
                    else if (evt_in.depth_upd)
                    begin
                        state_nxt.upd_addr = sbs_slot(evt_in.depth_id, 2'd2); // R15
                        state_nxt.upd_kind = 2'd2;
                        state_nxt.depth = evt_in.depth;
                        state_nxt.upd_ph = 2'd1;
                    end
                end
            end
            2'd1:
                state_nxt.upd_ph = 2'd2;
            2'd2:
            begin
                mem_we = 1'b1;
                if (state_r.upd_kind == 2'd2)
                    mem_wdata = (state_r.depth > mem_rdata) ? state_r.depth : mem_rdata; // R15
                state_nxt.upd_ph = 2'd0;
            end
            default:
                state_nxt.upd_ph = 2'd0;
        endcase

        // Command sequencing
        unique case (state_r.st)
            SBS_IDLE, SBS_DONE:
            begin
                state_nxt.st = SBS_IDLE;
                if (req_valid_in && is_cmd && state_r.upd_ph == 2'd0)
                begin
                    state_nxt.cmd_id = req_in.cmd_id; // R3
                    state_nxt.addr_mod = req_in.addr_mod; // R4
                    state_nxt.base = req_in.mem_addr; // R5
                    state_nxt.span16 = req_in.options[SBS_OPT_SPAN_BIT]; // R19 R8
                    state_nxt.word = 6'h00;
                    state_nxt.last = req_in.options[SBS_OPT_SPAN_BIT] ? SBS_LAST_16 : 6'(SBS_WORDS_8 - 6'h01);
                    state_nxt.rd_pend = 1'b0;
                    state_nxt.upd_ph = 2'd3; // Blocks new target updates while busy
                    if (req_in.options[SBS_OPT_WIPE_BIT]) // R19
                        state_nxt.st = SBS_WIPE; // R6
                    else
                        state_nxt.st = SBS_SEND;
                end
            end
            SBS_WIPE:
            begin
                mem_wipe = 1'b1; // R7
                state_nxt.total = SBS_CNT_RESET; // R6
                state_nxt.bad = SBS_CNT_RESET;
                state_nxt.parity = SBS_CNT_RESET;
                state_nxt.tsel = SBS_CNT_RESET;
                state_nxt.wiped = 1'b1;
                state_nxt.done = 1'b1;
                state_nxt.upd_ph = 2'd0;
                state_nxt.st = SBS_DONE;
            end
            SBS_SEND:
            begin
                state_nxt.upd_ph = 2'd3;
                mem_raddr = sbs_slot(tid, tfld);
                if (!state_r.wr.valid || wr_ready_in)
                begin
                    state_nxt.wr.valid = 1'b0;
                    if (tgt_word && tfld != 2'd3 && !state_r.rd_pend)
                        state_nxt.rd_pend = 1'b1; // Wait one cycle for memory read
                    else if (state_r.word > state_r.last)
                    begin
                        state_nxt.wiped = 1'b0;
                        state_nxt.done = 1'b1;
                        state_nxt.upd_ph = 2'd0;
                        state_nxt.st = SBS_DONE;
                    end
                    else
                    begin
                        state_nxt.rd_pend = 1'b0;
                        state_nxt.wr.valid = 1'b1;
                        state_nxt.wr.addr_mod = state_r.addr_mod; // R4
                        state_nxt.wr.addr = state_r.base + {24'h00_0000, state_r.word, 2'b00}; // R5 R16
                        if (!tgt_word)
                            state_nxt.wr.data = sbs_hdr_word(state_r, state_r.word);
                        // Final word of either layout is the closing reserved word
                        else if (tfld == 2'd3 || state_r.word == state_r.last
                            || (tfld == 2'd0 && (tid == own_id_in || !id_used_in[tid])))
                            state_nxt.wr.data = SBS_CNT_RESET; // R13 R16
                        else
                            state_nxt.wr.data = mem_rdata;
                        state_nxt.word = state_r.word + 6'h01;
                    end
                end
            end
            default:
                state_nxt.st = SBS_IDLE;
        endcase
    end

    // ======================================================================
    // State register
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            state_r <= '0; // R7
        else
            state_r <= state_nxt;
    end

    // Ready only when no per-target update is in flight; per-target events that arrive during a report are dropped
    assign req_ready_out = (state_r.st == SBS_IDLE || state_r.st == SBS_DONE) && state_r.upd_ph == 2'd0;
    assign wr_out = state_r.wr;
    assign done_out = state_r.done;
    assign done_id_out = state_r.cmd_id; // R3
    assign done_wiped_out = state_r.wiped;
endmodule : sbs_stats_report
`default_nettype wire

// >>> dv/sbs_stats_report_monitor.sv
// Port checker for the statistics report block
`timescale 1ns/1ps
`default_nettype none
module sbs_stats_report_monitor
    import sbs_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [3:0] own_id_in,
    input wire logic [15:0] id_used_in,
    input wire logic req_valid_in,
    input wire sbs_req_t req_in,
    input wire logic req_ready_out,
    input wire sbs_evt_t evt_in,
    input wire sbs_wr_t wr_out,
    input wire logic wr_ready_in,
    input wire logic done_out,
    input wire logic [31:0] done_id_out,
    input wire logic done_wiped_out
);
    // ======================================================================
    // Request capture
    logic take;
    logic [31:0] id_r;
    logic [31:0] base_r;
    logic [5:0] am_r;
    logic [5:0] idx_r;
    logic wipe_r;
    logic span_r;
    assign take = req_valid_in && req_ready_out && req_in.cmd_code == SBS_CMD_CODE;
    // Remember the taken request, count words the sink accepted
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            {id_r, base_r, am_r, idx_r, wipe_r, span_r} <= '0;
        end
        else if (take)
        begin
            {id_r, base_r, am_r} <= {req_in.cmd_id, req_in.mem_addr, req_in.addr_mod};
            {idx_r, wipe_r, span_r} <= {6'h00, req_in.options[0], req_in.options[1]};
        end
        else if (wr_out.valid && wr_ready_in)
        begin
            idx_r <= idx_r + 6'h01;
        end
    end
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    // ======================================================================
    // Properties
    property p_take_busy;
        take |=> !req_ready_out;
    endproperty
    a_take_busy: assert property (p_take_busy)
        else $error("ready stayed high after a take");
    property p_wr_hold;
        wr_out.valid && !wr_ready_in |=> wr_out.valid && $stable(wr_out);
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write word changed while stalled");
    property p_clr_done;
        take && req_in.options[0] |-> ##2 done_out && done_wiped_out;
    endproperty
    a_clr_done: assert property (p_clr_done)
        else $error("clear did not complete in two cycles");
    property p_clr_nowr;
        take && req_in.options[0] |=> (!wr_out.valid) [*3];
    endproperty
    a_clr_nowr: assert property (p_clr_nowr)
        else $error("clear produced a memory write");
    property p_done_id;
        done_out |-> done_id_out == id_r && done_wiped_out == wipe_r;
    endproperty
    a_done_id: assert property (p_done_id)
        else $error("completion identifier or kind wrong");
    property p_am;
        wr_out.valid |-> wr_out.addr_mod == am_r;
    endproperty
    a_am: assert property (p_am)
        else $error("address modifier differs from request");
    property p_addr;
        wr_out.valid |-> wr_out.addr == base_r + {24'h000000, idx_r, 2'b00};
    endproperty
    a_addr: assert property (p_addr)
        else $error("write address out of sequence");
    property p_rpt_done;
        take && !req_in.options[0] |-> ##[20:1000] done_out;
    endproperty
    a_rpt_done: assert property (p_rpt_done)
        else $error("report never completed");
    property p_span_cnt;
        done_out && !wipe_r |-> idx_r == (span_r ? 6'h35 : 6'h18);
    endproperty
    a_span_cnt: assert property (p_span_cnt)
        else $error("report word count wrong for layout");
    property p_hdr_rsv;
        wr_out.valid && wr_out.addr == base_r + 32'h1c |-> wr_out.data == 32'h0;
    endproperty
    a_hdr_rsv: assert property (p_hdr_rsv)
        else $error("reserved header word not zero");
    property p_last_rsv;
        wr_out.valid && span_r && wr_out.addr == base_r + 32'hd0 |-> wr_out.data == 32'h0;
    endproperty
    a_last_rsv: assert property (p_last_rsv)
        else $error("final reserved word not zero");
    c_stall: cover property (wr_out.valid && !wr_ready_in);
    c_clear: cover property (take && req_in.options[0]);
    c_span16: cover property (done_out && !wipe_r && span_r);
    c_span8: cover property (done_out && !wipe_r && !span_r);
endmodule : sbs_stats_report_monitor
bind sbs_stats_report sbs_stats_report_monitor sbs_stats_report_monitor_i (.clock_in, .rst_in, .own_id_in,
    .id_used_in, .req_valid_in, .req_in, .req_ready_out, .evt_in, .wr_out, .wr_ready_in, .done_out,
    .done_id_out, .done_wiped_out);
`default_nettype wire

// >>> dv/sbs_mem_model.sv
// System memory sink that takes the reported words with stalls
`timescale 1ns/1ps
`default_nettype none
module sbs_mem_model
    import sbs_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic slow_in,
    input wire sbs_wr_t wr_in,
    output logic ready_out
);
    logic [7:0] lfsr_r;
    logic [31:0] addr_q[$];
    logic [31:0] data_q[$];
    logic [5:0] am_q[$];
    // Stalls follow an LFSR so the block sees uneven back-pressure
    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lfsr_r <= 8'h5a;
            ready_out <= 1'b0;
        end
        else
        begin
            lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
            ready_out <= !slow_in || lfsr_r[0];
            if (wr_in.valid && ready_out)
            begin
                addr_q.push_back(wr_in.addr);
                data_q.push_back(wr_in.data);
                am_q.push_back(wr_in.addr_mod);
            end
        end
    end
endmodule : sbs_mem_model
`default_nettype wire

// >>> dv/sbs_stats_report_tb.sv
// Self-checking bench for the statistics report block
`timescale 1ns/1ps
`default_nettype none
module sbs_stats_report_tb
    import sbs_pkg::*;
;
    logic clock_in, rst_in, req_valid, req_ready, wr_ready, done, done_wiped, slow;
    logic [3:0] own_id;
    logic [15:0] id_used;
    logic [31:0] done_id;
    sbs_req_t req;
    sbs_evt_t evt;
    sbs_wr_t wr;
    int fails, checks_done, cyc, exp_tot, exp_bad, exp_par, exp_sel;
    int exp_cmd [16], exp_qf [16], exp_mx [16];
    logic [7:0] codes [9] = '{8'h16, 8'h16, 8'h06, 8'h16, 8'h16, 8'h18, 8'h16, 8'h16, 8'h16};
    logic [1:0] opts [9] = '{2'b10, 2'b00, 2'b00, 2'b11, 2'b00, 2'b10, 2'b01, 2'b10, 2'b10};
    int evn [9] = '{40, 25, 10, 10, 15, 5, 30, 0, 12};
    sbs_stats_report sbs_stats_report_i (.clock_in(clock_in), .rst_in(rst_in), .own_id_in(own_id),
        .id_used_in(id_used), .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready),
        .evt_in(evt), .wr_out(wr), .wr_ready_in(wr_ready), .done_out(done), .done_id_out(done_id),
        .done_wiped_out(done_wiped));
    sbs_mem_model sbs_mem_model_i (.clock_in(clock_in), .rst_in(rst_in), .slow_in(slow), .wr_in(wr),
        .ready_out(wr_ready));
    // ======================================================================
    // Helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // Model of a wipe or reset: every tally back to zero
    task automatic clear_exp;
        {exp_tot, exp_bad, exp_par, exp_sel} = '0;
        exp_cmd = '{default: 0};
        exp_qf = '{default: 0};
        exp_mx = '{default: 0};
    endtask : clear_exp
    // Expected per-target word: four words per id after the header, last word reserved
    function automatic logic [31:0] exp_tgt(input int i, input int w);
        int t;
        int f;
        t = (i - SBS_HDR_WORDS) / SBS_TGT_WORDS;
        f = (i - SBS_HDR_WORDS) % SBS_TGT_WORDS;
        if (f == 3 || i == w - 1)
            return 32'h0;
        if (f == 1)
            return 32'(exp_qf[t]);
        if (f == 2)
            return 32'(exp_mx[t]);
        if (4'(t) == own_id || !id_used[t])
            return 32'h0;
        return 32'(exp_cmd[t]);
    endfunction : exp_tgt
    // Random event pulses, tallied as they are sent
    // Per-target ones come three cycles apart and settle before the next request
    task automatic events(input int n);
        sbs_evt_t e;
        int t;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clock_in);
            e = '0;
            e.cmd_done = 1'($urandom_range(1));
            e.bad_status = 1'($urandom_range(1));
            e.parity_err = 1'($urandom_range(1));
            e.target_sel = 1'($urandom_range(1));
            t = $urandom_range(15);
            if (i % 3 == 0 && i + 2 <= n)
            begin
                case ($urandom_range(2))
                    0:
                    begin
                        e.tgt_cmd = 1'b1;
                        e.tgt_cmd_id = 4'(t);
                        exp_cmd[t]++;
                    end
                    1:
                    begin
                        e.queue_full = 1'b1;
                        e.qf_id = 4'(t);
                        exp_qf[t]++;
                    end
                    default:
                    begin
                        e.depth_upd = 1'b1;
                        e.depth_id = 4'(t);
                        e.depth = 32'($urandom_range(200));
                        if (e.depth > exp_mx[t])
                            exp_mx[t] = int'(e.depth);
                    end
                endcase
            end
            evt <= e;
            exp_tot += e.cmd_done;
            exp_bad += e.bad_status;
            exp_par += e.parity_err;
            exp_sel += e.target_sel;
        end
        @(posedge clock_in);
        evt <= '0;
    endtask : events
    // One request, then wait for completion and compare what memory got
    task automatic run(input logic [7:0] code, input logic [7:0] opt);
        sbs_req_t r;
        int n;
        int w;
        r.cmd_id = $urandom;
        r.addr_mod = 6'($urandom_range(63));
        r.mem_addr = {16'h0000, 8'($urandom_range(255)), 8'h00};
        r.cmd_code = code;
        r.options = opt;
        sbs_mem_model_i.addr_q.delete();
        sbs_mem_model_i.data_q.delete();
        sbs_mem_model_i.am_q.delete();
        @(posedge clock_in);
        req <= r;
        req_valid <= 1'b1;
        @(posedge clock_in);
        req_valid <= 1'b0;
        req <= ~r;
        n = 0;
        while (done !== 1'b1 && n < 600)
        begin
            @(negedge clock_in);
            n++;
        end
        w = (code != SBS_CMD_CODE || opt[0]) ? 0 : (opt[1] ? 53 : 24);
        check("word_count", sbs_mem_model_i.addr_q.size(), w);
        check("done_seen", done, code == SBS_CMD_CODE);
        if (code == SBS_CMD_CODE)
        begin
            check("done_id", done_id, r.cmd_id);
            check("done_wiped", done_wiped, opt[0]);
        end
        if (w > 0)
        begin
            check("first_addr", sbs_mem_model_i.addr_q[0], r.mem_addr);
            check("last_addr", sbs_mem_model_i.addr_q[w-1], r.mem_addr + (opt[1] ? 32'hd0 : 32'h5c));
            check("addr_mod", sbs_mem_model_i.am_q[w-1], r.addr_mod);
            check("total", sbs_mem_model_i.data_q[0], exp_tot);
            check("bad_status", sbs_mem_model_i.data_q[1], exp_bad);
            check("parity", sbs_mem_model_i.data_q[2], exp_par);
            check("target_sel", sbs_mem_model_i.data_q[3], exp_sel);
            check("hdr_rsv", sbs_mem_model_i.data_q[7], 32'h0);
            for (int i = SBS_HDR_WORDS; i < w; i++)
                check("tgt_word", sbs_mem_model_i.data_q[i], exp_tgt(i, w));
        end
        if (code == SBS_CMD_CODE && opt[0])
            clear_exp();
    endtask : run
    // ======================================================================
    // Clock and cycle limit
    initial
    begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    always @(posedge clock_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            fails++;
            test_done();
        end
    end
    // ======================================================================
    // Main sequence: reports accumulate, clears and reset restart the tally
    initial
    begin
        void'($urandom(57));
        {fails, checks_done, cyc, exp_tot, exp_bad, exp_par, exp_sel} = '0;
        {req_valid, slow, req, evt} = '0;
        rst_in = 1'b1;
        own_id = 4'($urandom_range(15));
        id_used = 16'($urandom);
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        for (int k = 0; k < 9; k++)
        begin
            slow <= k[0];
            events(evn[k]);
            run(codes[k], {6'($urandom_range(63)), opts[k]});
            if (k == 7)
            begin
                events(10);
                rst_in <= 1'b1;
                repeat (2) @(posedge clock_in);
                rst_in <= 1'b0;
                clear_exp();
            end
        end
        test_done();
    end
endmodule : sbs_stats_report_tb
`default_nettype wire
